// [hw/aolp_regs.vh]
// Constants of the converter output latency path.
// What this block does
// - A sample is taken on each rising edge of the sample clock.
// - Samples advance one stage per edge; raw result appears ten cycles later.
// - Each result is a 12-bit word, sent as DDR LVDS or parallel CMOS.
// - Words are coded as straight offset binary or two's complement.
// - Processing functions add extra cycles of delay to the output path.
// - Low-latency mode passes the raw result after ten cycles, skipping processing.
// - After reset the block is in low-latency mode, processing inactive.
// - A serial configuration transfer is an 8-bit address then 8-bit data.
// - Coding comes from a serial bit or the coding-select pin in pin mode.
// - Overdriven input clamps the word to positive or negative full scale.
`ifndef AOLP_REGS_VH
`define AOLP_REGS_VH
`define AOLP_DATA_W 12
`define AOLP_RAW_LAT 10
`define AOLP_PROC_EXTRA 4
`define AOLP_FIFO_DEPTH 16
`define AOLP_CFG_AW 8
`define AOLP_CFG_DW 8
`define AOLP_CFG_ADDR_MODE 8'h42
`define AOLP_BIT_FAST_DIS 3
`define AOLP_BIT_TWOS 1
`define AOLP_BIT_GAIN_EN 0
`define AOLP_BIT_CMOS 2
`define AOLP_MIDSCALE 12'h800
`define AOLP_FULL_POS 12'hfff
`define AOLP_FULL_NEG 12'h000
`endif

// [hw/aolp_delay.v]
// Fixed-length delay line for one data word.
module aolp_delay #(
  parameter W = 13,
  parameter N = 10
) (
  input wire mclk,
  input wire arst_n,
  input wire step,
  input wire [W-1:0] din,
  output wire [W-1:0] dout
);
  reg [W-1:0] stage_q [0:N-1];
  integer i;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      for (i = 0; i < N; i = i + 1) begin
        stage_q[i] <= {W{1'b0}};
      end
    end else if (step) begin
      stage_q[0] <= din;
      for (i = 1; i < N; i = i + 1) begin
        stage_q[i] <= stage_q[i-1];
      end
    end
  end
  assign dout = stage_q[N-1];
endmodule // aolp_delay

// [hw/aolp_fifo.v]
// Small flip-flop FIFO with valid and ready on both sides.
module aolp_fifo #(
  parameter W = 12,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire mclk,
  input wire arst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [W-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [W-1:0] out_data
);
  reg [W-1:0] mem_q [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push;
  wire pop;
  assign in_ready = (cnt_q != DEPTH[AW:0]);
  assign out_valid = (cnt_q != {(AW+1){1'b0}});
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  always @(posedge mclk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= wr_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (pop) begin
        rd_q <= rd_q + {{(AW-1){1'b0}}, 1'b1};
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + {{AW{1'b0}}, 1'b1};
      end else if (pop && !push) begin
        cnt_q <= cnt_q - {{AW{1'b0}}, 1'b1};
      end
    end
  end
endmodule // aolp_fifo

// [hw/aolp_top.v]
// Output path of the sampling converter: sampling, latency, coding and output stage.
`include "aolp_regs.vh"
module aolp_top #(
  parameter W = `AOLP_DATA_W,
  parameter RAW_LAT = `AOLP_RAW_LAT,
  parameter PROC_EXTRA = `AOLP_PROC_EXTRA,
  parameter DEPTH = `AOLP_FIFO_DEPTH
) (
  input wire mclk,
  input wire arst_n,
  input wire sample_clk,
  input wire [W-1:0] conv_raw,
  input wire ovr_pos,
  input wire ovr_neg,
  input wire cfg_pin_mode,
  input wire coding_select_pin,
  input wire cfg_valid,
  input wire [`AOLP_CFG_AW-1:0] cfg_addr,
  input wire [`AOLP_CFG_DW-1:0] cfg_data,
  input wire rx_ready,
  output reg [W-1:0] cmos_data,
  output reg [W/2-1:0] lvds_data,
  output reg out_valid,
  output reg out_clk,
  output reg fifo_stall,
  output reg fast_mode
);
  reg sclk_s1_q;
  reg sclk_s2_q;
  reg sclk_s3_q;
  reg sclk_lvl_q;
  reg [`AOLP_CFG_DW-1:0] mode_q;
  reg [W-1:0] proc_word_q;
  reg [W-1:0] word_q;
  reg word_vld_q;
  reg [W-1:0] hold_q;
  reg half_q;
  wire sclk_rise;
  wire sclk_fall;
  wire fast_dis;
  wire twos;
  wire cmos_sel;
  wire gain_en;
  wire [W:0] samp_word;
  wire [W:0] raw_out;
  wire [W:0] proc_out;
  wire [W-1:0] clamped;
  wire [W-1:0] coded;
  wire f_in_ready;
  wire f_out_valid;
  wire [W-1:0] f_out_data;
  wire pull;
  // A level changes only when the second and third stages agree on the new value.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      sclk_s1_q <= 1'b0;
      sclk_s2_q <= 1'b0;
      sclk_s3_q <= 1'b0;
      sclk_lvl_q <= 1'b0;
    end else begin
      sclk_s1_q <= sample_clk;
      sclk_s2_q <= sclk_s1_q;
      sclk_s3_q <= sclk_s2_q;
      if (sclk_s2_q == sclk_s3_q) begin
        sclk_lvl_q <= sclk_s3_q;
      end
    end
  end
  assign sclk_rise = (sclk_s2_q == sclk_s3_q) && sclk_s3_q && !sclk_lvl_q;
  assign sclk_fall = (sclk_s2_q == sclk_s3_q) && !sclk_s3_q && sclk_lvl_q;
  // Serial transfers carry one address byte and one data byte per write.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      mode_q <= {`AOLP_CFG_DW{1'b0}};
    end else if (cfg_valid && cfg_addr == `AOLP_CFG_ADDR_MODE) begin
      mode_q <= cfg_data;
    end
  end
  assign fast_dis = mode_q[`AOLP_BIT_FAST_DIS];
  // Processing bits are ignored while low latency is on, so enabling them first has no effect.
  assign gain_en = fast_dis && mode_q[`AOLP_BIT_GAIN_EN];
  assign twos = cfg_pin_mode ? coding_select_pin : mode_q[`AOLP_BIT_TWOS];
  assign cmos_sel = mode_q[`AOLP_BIT_CMOS];
  // The analog front end clips, so overdrive forces the full-scale codes.
  assign clamped = ovr_pos ? `AOLP_FULL_POS : (ovr_neg ? `AOLP_FULL_NEG : conv_raw);
  assign samp_word = {1'b1, clamped};
  aolp_delay #(
    .W(W + 1),
    .N(RAW_LAT)
  ) u_raw (
    .mclk(mclk),
    .arst_n(arst_n),
    .step(sclk_rise),
    .din(samp_word),
    .dout(raw_out)
  );
  // Both paths always run, so switching modes never changes a path's own delay.
  // The processing register is the first of the extra stages, so the line holds one fewer.
  aolp_delay #(
    .W(W + 1),
    .N(PROC_EXTRA - 1)
  ) u_proc (
    .mclk(mclk),
    .arst_n(arst_n),
    .step(sclk_rise),
    .din({raw_out[W], proc_word_q}),
    .dout(proc_out)
  );
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      proc_word_q <= {W{1'b0}};
    end else if (sclk_rise) begin
      // Processing stand-in: one-bit gain shift with saturation.
      // Offset binary: the two top bits differ only within quarter scale of midscale.
      if (gain_en && raw_out[W-1] != raw_out[W-2]) begin
        proc_word_q <= {raw_out[W-1], raw_out[W-3:0], 1'b0};
      end else if (gain_en) begin
        proc_word_q <= raw_out[W-1] ? `AOLP_FULL_POS : `AOLP_FULL_NEG;
      end else begin
        proc_word_q <= raw_out[W-1:0];
      end
    end
  end
  assign coded = twos ? (word_q ^ `AOLP_MIDSCALE) : word_q;
  // One word enters the FIFO per sample edge once the pipeline has filled.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      word_q <= {W{1'b0}};
      word_vld_q <= 1'b0;
    end else begin
      word_vld_q <= 1'b0;
      if (sclk_rise) begin
        if (fast_dis) begin
          word_q <= proc_out[W-1:0];
          word_vld_q <= proc_out[W];
        end else begin
          word_q <= raw_out[W-1:0];
          word_vld_q <= raw_out[W];
        end
      end
    end
  end
  aolp_fifo #(
    .W(W),
    .DEPTH(DEPTH),
    .AW(4)
  ) u_fifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(word_vld_q),
    .in_ready(f_in_ready),
    .in_data(coded),
    .out_valid(f_out_valid),
    .out_ready(pull),
    .out_data(f_out_data)
  );
  // The receiver is paced by the sample clock; a held-off receiver fills the FIFO.
  assign pull = sclk_rise && f_out_valid && rx_ready;
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cmos_data <= {W{1'b0}};
      lvds_data <= {(W/2){1'b0}};
      hold_q <= {W{1'b0}};
      half_q <= 1'b0;
      out_valid <= 1'b0;
      out_clk <= 1'b0;
      fifo_stall <= 1'b0;
      fast_mode <= 1'b1;
    end else begin
      fast_mode <= !fast_dis;
      fifo_stall <= !f_in_ready && word_vld_q;
      if (sclk_rise) begin
        out_clk <= 1'b1;
        out_valid <= pull;
        if (pull) begin
          cmos_data <= cmos_sel ? f_out_data : {W{1'b0}};
          hold_q <= f_out_data;
          lvds_data <= cmos_sel ? {(W/2){1'b0}} : {f_out_data[10], f_out_data[8], f_out_data[6],
                                                  f_out_data[4], f_out_data[2], f_out_data[0]};
        end
        half_q <= 1'b1;
      end else if (sclk_fall) begin
        out_clk <= 1'b0;
        if (half_q && !cmos_sel) begin
          lvds_data <= {hold_q[11], hold_q[9], hold_q[7], hold_q[5], hold_q[3], hold_q[1]};
        end
        half_q <= 1'b0;
      end
    end
  end
endmodule // aolp_top

// [sim/aolp_rx.sv]
// Capture receiver model that can hold words back in the output FIFO.
module aolp_rx (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic hold,
  output logic rx_ready
);
  timeunit 1ns;
  timeprecision 1ns;
  // Ready is registered, so a stall reaches the FIFO one cycle late, as a real receiver would.
  always @(posedge mclk or negedge arst_n) begin
    if (!arst_n) rx_ready <= 1'b0;
    else rx_ready <= !hold;
  end
endmodule // aolp_rx

// [sim/aolp_top_monitor.sv]
// Port checker for the converter output path.
module aolp_top_monitor #(
  parameter W = 12
) (
  input wire mclk,
  input wire arst_n,
  input wire sample_clk,
  input wire cfg_valid,
  input wire [7:0] cfg_addr,
  input wire [7:0] cfg_data,
  input wire [W-1:0] cmos_data,
  input wire out_valid,
  input wire out_clk,
  input wire fifo_stall,
  input wire fast_mode
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!arst_n);
  AST_RST_FAST: assert property ($rose(arst_n) |-> fast_mode) else $error("no fast mode after reset");
  AST_RST_IDLE: assert property ($rose(arst_n) |-> !out_valid && !fifo_stall) else $error("busy after reset");
  AST_FAST_OFF: assert property (cfg_valid && cfg_addr == 8'h42 && cfg_data[3] |-> ##[1:3] !fast_mode)
    else $error("fast mode not left");
  AST_FAST_ON: assert property (cfg_valid && cfg_addr == 8'h42 && !cfg_data[3] |-> ##[1:3] fast_mode)
    else $error("fast mode not set");
  AST_BAD_ADDR: assert property (cfg_valid && cfg_addr != 8'h42 |=> $stable(fast_mode))
    else $error("other address changed mode");
  AST_CLK_RISE: assert property ($rose(sample_clk) |-> ##[2:6] $rose(out_clk)) else $error("out clock late");
  AST_CLK_FALL: assert property ($fell(sample_clk) |-> ##[2:6] $fell(out_clk)) else $error("out clock fall late");
  AST_WORD_HOLD: assert property ($fell(out_clk) |-> $stable(cmos_data) && $stable(out_valid))
    else $error("word changed mid cycle");
  AST_DROP_PULSE: assert property (fifo_stall |=> !fifo_stall) else $error("drop flag too long");
endmodule // aolp_top_monitor
bind aolp_top aolp_top_monitor #(.W(W)) i_mon (.mclk(mclk), .arst_n(arst_n), .sample_clk(sample_clk),
  .cfg_valid(cfg_valid), .cfg_addr(cfg_addr), .cfg_data(cfg_data), .cmos_data(cmos_data),
  .out_valid(out_valid), .out_clk(out_clk), .fifo_stall(fifo_stall), .fast_mode(fast_mode));

// [sim/aolp_top_test.sv]
// Self-checking bench for the converter output path.
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin err_count++; $display("CHECK FAILED %0t: %h not %h", $time, a, b); end end
module aolp_top_test;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 0, arst_n = 0, sample_clk = 0, ovr_pos = 0, ovr_neg = 0, pin_mode = 0, pin_twos = 0;
  logic cfg_valid = 0, hold = 0, seen = 0;
  logic [7:0] cfg_addr = 8'h00, cfg_data = 8'h00;
  logic [11:0] conv_raw = 12'h000;
  logic [13:0] hist [0:4095];
  logic [13:0] v;
  logic [31:0] r;
  wire [11:0] cmos_data;
  wire [5:0] lvds_data;
  wire out_valid, out_clk, fifo_stall, fast_mode, rx_ready;
  int err_count = 0, comparisons = 0, n = 0, ph = 0;
  always #10 mclk = ~mclk;
  // Sample clock of 160 ns made from the bench clock; a new raw code comes with every rise.
  always @(posedge mclk) begin
    ph <= (ph + 1) % 8;
    sample_clk <= (ph + 1) % 8 < 4;
    if (fifo_stall === 1'b1) seen <= 1'b1;
    if (ph == 7) begin
      r = (n == 0) ? $urandom(26708) : $urandom;
      v = {r[14:12] == 3'h0, r[14:12] == 3'h1, r[11:0]};
      {ovr_pos, ovr_neg, conv_raw} <= v;
      hist[n] <= v;
      n <= n + 1;
    end
  end
  function automatic logic [11:0] expw(logic [13:0] s, logic twos, logic g);
    logic [11:0] w;
    w = s[13] ? 12'hfff : s[12] ? 12'h000 : s[11:0];
    if (g) w = (w[11] == w[10]) ? {12{w[11]}} : {w[11], w[9:0], 1'b0};
    return {w[11] ^ twos, w[10:0]};
  endfunction
  function automatic logic [5:0] half(logic [11:0] w, int s);
    for (int i = 0; i < 6; i++) half[i] = w[2*i+s];
  endfunction
  task automatic at_ph(int p);
    do begin
      @(posedge mclk);
      #1;
    end while (ph != p);
  endtask
  task automatic cfg(logic [7:0] a, logic [7:0] d);
    @(posedge mclk);
    cfg_valid <= 1'b1;
    cfg_addr <= a;
    cfg_data <= d;
    @(posedge mclk);
    cfg_valid <= 1'b0;
    repeat (16) at_ph(0);
  endtask
  task automatic run(string nm, int lat, logic twos, logic lvds, logic g = 1'b0);
    repeat (8) begin
      at_ph(6);
      if (lvds) `CHK(lvds_data, half(expw(hist[n-1-lat], twos, g), 0))
      else `CHK(cmos_data, expw(hist[n-1-lat], twos, g))
      `CHK(out_valid, 1'b1)
      if (lvds) begin
        at_ph(2);
        `CHK(lvds_data, half(expw(hist[n-2-lat], twos, g), 1))
      end
    end
    $display("test %s done", nm);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    repeat (14) at_ph(0);
    `CHK(fast_mode, 1'b1)
    run("fast_lvds", 11, 0, 1);
    cfg(8'h42, 8'h05);
    run("fast_cmos", 11, 0, 0);
    cfg(8'h42, 8'h06);
    run("twos", 11, 1, 0);
    cfg(8'h41, 8'h08);
    `CHK(fast_mode, 1'b1)
    cfg(8'h42, 8'h0c);
    `CHK(fast_mode, 1'b0)
    run("processed", 15, 0, 0);
    cfg(8'h42, 8'h0d);
    run("gain", 15, 0, 0, 1);
    @(posedge mclk);
    pin_mode <= 1'b1;
    pin_twos <= 1'b1;
    cfg(8'h42, 8'h04);
    run("pin_coding", 11, 1, 0);
    @(posedge mclk);
    pin_mode <= 1'b0;
    cfg(8'h42, 8'h0c);
    @(posedge mclk);
    hold <= 1'b1;
    repeat (30) at_ph(0);
    at_ph(6);
    `CHK(out_valid, 1'b0)
    `CHK(seen, 1'b1)
    $display("test stall done");
    @(posedge mclk);
    hold <= 1'b0;
    arst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    arst_n <= 1'b1;
    #1;
    `CHK(fast_mode, 1'b1)
    repeat (14) at_ph(0);
    run("second_reset", 11, 0, 1);
    results();
  end
  // The whole sequence needs about 40 us; five times that means a hang.
  initial begin
    #200us;
    err_count++;
    results();
  end
  aolp_top #(.W(12)) i_dut (.mclk(mclk), .arst_n(arst_n), .sample_clk(sample_clk), .conv_raw(conv_raw),
    .ovr_pos(ovr_pos), .ovr_neg(ovr_neg), .cfg_pin_mode(pin_mode), .coding_select_pin(pin_twos),
    .cfg_valid(cfg_valid), .cfg_addr(cfg_addr), .cfg_data(cfg_data), .rx_ready(rx_ready),
    .cmos_data(cmos_data), .lvds_data(lvds_data), .out_valid(out_valid), .out_clk(out_clk),
    .fifo_stall(fifo_stall), .fast_mode(fast_mode));
  aolp_rx i_rx (.mclk(mclk), .arst_n(arst_n), .hold(hold), .rx_ready(rx_ready));
endmodule // aolp_top_test
